/* dpac_port_ctrl.sv */
// Controller driving one port of an asynchronous dual-port RAM
module dpac_port_ctrl #(
  parameter int AW = 13,
  parameter int DW = 8,
  parameter bit OE_LOW_WRITE = 1'b0
) (
  // Clock, reset, enable
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          clkEn,
  // User request
  input  wire logic          reqValid,
  input  wire logic [1:0]    reqOp,
  input  wire logic [AW-1:0] reqAddr,
  input  wire logic [DW-1:0] reqData,
  output logic               reqReady,
  output logic               rspValid,
  output logic [DW-1:0]      rspData,
  // Device pins
  output logic               ramSelN,
  output logic               tokenSelN,
  output logic               writeN,
  output logic               outEnN,
  output logic [AW-1:0]      addr,
  input  wire logic [DW-1:0] dataIn,
  output logic [DW-1:0]      dataOut,
  output logic               dataOe,
  input  wire logic          busyN
);
  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    IDLE, SETUP, STROBE, RECOVER, FLAGPULSE, FLAGGAP
  } dpac_state_t;

  localparam logic [3:0] WR_CYC = 4'(OE_LOW_WRITE ?
    ((dpac_pkg::WRITE_OE_LOW_CYC > dpac_pkg::WRITE_PULSE_CYC) ?
      dpac_pkg::WRITE_OE_LOW_CYC : dpac_pkg::WRITE_PULSE_CYC) :
    dpac_pkg::WRITE_PULSE_CYC);
  localparam logic [3:0] RD_CYC = 4'(dpac_pkg::READ_CYC);
  localparam logic [3:0] TK_CYC = 4'(dpac_pkg::TOKEN_PULSE_CYC);

  dpac_state_t                 state_q, state_d;
  logic [dpac_pkg::CNT_W-1:0]  cnt_q, cnt_d;
  logic [1:0]                  op_q, op_d;
  logic                        ramSelN_q, ramSelN_d;
  logic                        tokenSelN_q, tokenSelN_d;
  logic                        writeN_q, writeN_d;
  logic                        outEnN_q, outEnN_d;
  logic [AW-1:0]               addr_q, addr_d;
  logic [DW-1:0]               dOut_q, dOut_d;
  logic                        dOe_q, dOe_d;
  logic                        ready_q, ready_d;
  logic                        rsp_q, rsp_d;
  logic                        capture;

  function automatic logic is_write(input logic [1:0] op);
    return op == dpac_pkg::DPAC_WR_RAM || op == dpac_pkg::DPAC_WR_TOKEN;
  endfunction
  function automatic logic is_token(input logic [1:0] op);
    return op == dpac_pkg::DPAC_RD_TOKEN || op == dpac_pkg::DPAC_WR_TOKEN;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    op_d        = op_q;
    ramSelN_d   = ramSelN_q;
    tokenSelN_d = tokenSelN_q;
    writeN_d    = writeN_q;
    outEnN_d    = outEnN_q;
    addr_d      = addr_q;
    dOut_d      = dOut_q;
    dOe_d       = dOe_q;
    ready_d     = ready_q;
    rsp_d       = 1'b0;
    capture     = 1'b0;
    unique case (state_q)
      IDLE:
      begin
        if (reqValid && ready_q)
        begin
          // Address moves only while strobe and selects are high
          op_d    = reqOp;
          addr_d  = reqAddr;
          ready_d = 1'b0;
          if (is_token(reqOp))
            dOut_d = {reqData[DW-1:1], reqData[0]};
          else
            dOut_d = reqData;
          cnt_d   = '0;
          state_d = is_token(reqOp) && !is_write(reqOp) ? FLAGPULSE : SETUP;
        end
      end
      FLAGPULSE:
      begin
        // Fresh token select pulse latches the flag state
        tokenSelN_d = 1'b0;
        outEnN_d    = 1'b0;
        cnt_d       = cnt_q + 4'h1;
        if (cnt_q == TK_CYC)
        begin
          tokenSelN_d = 1'b1;
          outEnN_d    = 1'b1;
          cnt_d       = '0;
          state_d     = FLAGGAP;
        end
      end
      FLAGGAP:
        state_d = SETUP;
      SETUP:
      begin
        // Select chooses array or token latches
        ramSelN_d   = is_token(op_q);
        tokenSelN_d = !is_token(op_q);
        outEnN_d    = is_write(op_q) ? !OE_LOW_WRITE : 1'b0;
        writeN_d    = 1'b1;
        cnt_d       = '0;
        state_d     = STROBE;
      end
      STROBE:
      begin
        if (is_write(op_q))
        begin
          // Array write waits while slave busy input is low
          if (!is_token(op_q) && !busyN)
          begin
            // A cut pulse starts again at full width
            writeN_d = 1'b1;
            cnt_d    = '0;
          end
          else
          begin
            writeN_d = 1'b0;
            dOe_d    = 1'b1;
            cnt_d    = cnt_q + 4'h1;
          end
          if (cnt_q == WR_CYC)
          begin
            writeN_d = 1'b1;
            state_d  = RECOVER;
          end
        end
        else
        begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == RD_CYC)
          begin
            capture = 1'b1;
            state_d = RECOVER;
          end
        end
      end
      RECOVER:
      begin
        // Selects rise after the strobe; data held one cycle past write end
        ramSelN_d   = 1'b1;
        tokenSelN_d = 1'b1;
        outEnN_d    = 1'b1;
        dOe_d       = 1'b0;
        rsp_d       = 1'b1;
        ready_d     = 1'b1;
        state_d     = IDLE;
      end
      default:
        state_d = IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_q     <= IDLE;
      cnt_q       <= '0;
      op_q        <= 2'h0;
      ramSelN_q   <= 1'b1;
      tokenSelN_q <= 1'b1;
      writeN_q    <= 1'b1;
      outEnN_q    <= 1'b1;
      addr_q      <= '0;
      dOut_q      <= '0;
      dOe_q       <= 1'b0;
      ready_q     <= 1'b1;
      rsp_q       <= 1'b0;
    end
    else if (clkEn)
    begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      op_q        <= op_d;
      ramSelN_q   <= ramSelN_d;
      tokenSelN_q <= tokenSelN_d;
      writeN_q    <= writeN_d;
      outEnN_q    <= outEnN_d;
      addr_q      <= addr_d;
      dOut_q      <= dOut_d;
      dOe_q       <= dOe_d;
      ready_q     <= ready_d;
      rsp_q       <= rsp_d;
    end
  end

  dpac_data_reg #(.DW(DW)) u_data (
    .mclk  (mclk),
    .reset (reset),
    .ce    (clkEn),
    .load  (capture),
    .din   (dataIn),
    .dout  (rspData)
  );

  assign ramSelN   = ramSelN_q;
  assign tokenSelN = tokenSelN_q;
  assign writeN    = writeN_q;
  assign outEnN    = outEnN_q;
  assign addr      = addr_q;
  assign dataOut   = dOut_q;
  assign dataOe    = dOe_q;
  assign reqReady  = ready_q;
  assign rspValid  = rsp_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_addr_stable: assert property ($changed(addr) |-> $past(writeN))
    else $error("address moved while strobe low");
  chk_read_strobe: assert property
    (!writeN |-> is_write(op_q))
    else $error("strobe low during a read");
  chk_sel_excl: assert property (!(ramSelN == 1'b0 && tokenSelN == 1'b0))
    else $error("both selects low");
  chk_write_sel: assert property
    (!writeN |-> (ramSelN != tokenSelN))
    else $error("write strobe without a select");
  chk_busy_hold: assert property
    (clkEn && state_q == STROBE && is_write(op_q) && !is_token(op_q)
     && !busyN && cnt_q != WR_CYC |=> writeN)
    else $error("array write while busy low");
  chk_pulse_width: assert property
    (clkEn && $fell(writeN) |-> !writeN [*2])
    else $error("write pulse too short");
  chk_flag_pulse: assert property
    (state_q == FLAGGAP |-> $past(tokenSelN, 2) == 1'b0)
    else $error("no token pulse before flag read");
  chk_addr_before_sel: assert property
    ($fell(ramSelN) |-> $stable(addr))
    else $error("address changed with select fall");
  chk_data_drive: assert property
    (!writeN |=> dataOe || writeN)
    else $error("data not driven during write");

  cov_ram_write:  cover property (state_q == STROBE && op_q == 2'h1);
  cov_ram_read:   cover property (capture && op_q == 2'h0);
  cov_token_wr:   cover property (state_q == RECOVER && op_q == 2'h3);
  cov_busy_stall: cover property (!busyN && state_q == STROBE);
endmodule

/* dpac_pkg.sv */
// Package of timing constants and enumerations for the dual-port RAM port controller
package dpac_pkg;
  // Clock period in picoseconds (125 MHz)
  localparam int CLK_PERIOD_PS = 8000;
  // Write pulse width, ns
  localparam int WRITE_PULSE_WIDTH_NS = 12;
  // Strobe low to data float, ns
  localparam int STROBE_TO_FLOAT_TIME_NS = 10;
  // Data setup to write end, ns
  localparam int DATA_SETUP_TIME_NS = 10;
  // Token flag update pulse, ns
  localparam int TOKEN_UPDATE_PULSE_NS = 10;
  // Address to data valid on a read, ns
  localparam int READ_ACCESS_NS = 15;
  // Least times round up to whole cycles
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int WRITE_PULSE_CYC = cyc_up(WRITE_PULSE_WIDTH_NS);
  localparam int WRITE_OE_LOW_CYC =
    cyc_up(STROBE_TO_FLOAT_TIME_NS + DATA_SETUP_TIME_NS);
  localparam int TOKEN_PULSE_CYC = cyc_up(TOKEN_UPDATE_PULSE_NS);
  localparam int READ_CYC = cyc_up(READ_ACCESS_NS);
  localparam int CNT_W = 4;
  // Request kinds from the user side
  typedef enum logic [1:0] {
    DPAC_RD_RAM,
    DPAC_WR_RAM,
    DPAC_RD_TOKEN,
    DPAC_WR_TOKEN
  } dpac_op_t;
endpackage

/* dpac_data_reg.sv */
// Data capture register holding the last word read from the device
module dpac_data_reg #(
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          ce,
  // Capture
  input  wire logic          load,
  input  wire logic [DW-1:0] din,
  output logic      [DW-1:0] dout
);
  logic [DW-1:0] data_q;
  logic [DW-1:0] data_d;

  always_comb
  begin
    data_d = load ? din : data_q;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      data_q <= '0;
    else if (ce)
      data_q <= data_d;
  end

  assign dout = data_q;
endmodule

/* dpac_ram_model.sv */
// Behavioural model of one port of the dual-port RAM
module dpac_ram_model #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  // Pins from the controller
  input  wire logic          ramSelN,
  input  wire logic          tokenSelN,
  input  wire logic          writeN,
  input  wire logic          outEnN,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] dataOut,
  input  wire logic          dataOe,
  // Pins to the controller
  output logic      [DW-1:0] dataIn,
  output logic               busyN,
  // Bench control
  input  wire logic          busyHold
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DW-1:0] mem [2**AW];
  logic [7:0]    tokFree = 8'hFF;
  logic [7:0]    tokView = 8'hFF;
  logic          wrRam;
  logic          wrTok;
  logic [DW-1:0] wrVal;
  // Bench stands in for the far port winning the arbitration
  assign busyN = ~busyHold;
  assign wrRam = !ramSelN && tokenSelN && !writeN;
  assign wrTok = ramSelN && !tokenSelN && !writeN;
  // An undriven bus is stored as garbage
  assign wrVal = dataOe ? dataOut : ~dataOut;
  always @(negedge wrRam)
    if (busyN)
      mem[addr] = wrVal;
  always @(negedge wrTok)
    tokFree[addr[2:0]] = wrVal[0];
  // Flag seen by reads follows tokFree at each rise of outEnN or tokenSelN, ending any read or token access
  always @(posedge outEnN or posedge tokenSelN)
    tokView = tokFree;
  // Data pins float while writing or deselected
  always_comb
    if (outEnN || !writeN)
      dataIn = ~mem[addr];
    else if (!ramSelN && tokenSelN)
      dataIn = mem[addr];
    else if (ramSelN && !tokenSelN)
      dataIn = {DW{tokView[addr[2:0]]}};
    else
      dataIn = ~mem[addr];
endmodule

/* tb_dual_port_ram_arbitration.sv */
// Self-checking bench for the dual-port RAM port controller
module tb_dual_port_ram_arbitration;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, reset, clkEn, reqValid, reqReady, rspValid;
  logic [1:0]  reqOp;
  logic [12:0] reqAddr, addr, prevAddr;
  logic [7:0]  reqData, rspData, dataIn, dataOut, rd;
  logic        ramSelN, tokenSelN, writeN, outEnN, dataOe, busyN;
  logic        busyHold, done;
  int          error_cnt, comparisons, cycles;
  dpac_port_ctrl #(.AW(13), .DW(8)) u_dpac_port_ctrl (
    .mclk(mclk), .reset(reset), .clkEn(clkEn), .reqValid(reqValid),
    .reqOp(reqOp), .reqAddr(reqAddr), .reqData(reqData),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
    .ramSelN(ramSelN), .tokenSelN(tokenSelN), .writeN(writeN),
    .outEnN(outEnN), .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .busyN(busyN));
  dpac_ram_model #(.AW(13), .DW(8)) u_dpac_ram_model (
    .ramSelN(ramSelN), .tokenSelN(tokenSelN), .writeN(writeN),
    .outEnN(outEnN), .addr(addr), .dataOut(dataOut), .dataOe(dataOe),
    .dataIn(dataIn), .busyN(busyN), .busyHold(busyHold));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One access; holds the request until it is taken
  task automatic do_op(input logic [1:0] op, input logic [12:0] a,
                       input logic [7:0] d, output logic [7:0] r);
    int n;
    reqOp <= op;
    reqAddr <= a;
    reqData <= d;
    reqValid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (reqReady !== 1'b1 && n < 100);
    reqValid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (rspValid !== 1'b1 && n < 200);
    check(rspValid, 1'b1);
    r = rspData;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_idle_tokens();
    check({ramSelN, tokenSelN, writeN, outEnN, dataOe}, 5'h1E);
    for (int i = 0; i < 8; i++)
    begin
      do_op(2'h2, 13'(i), 8'h00, rd);
      check(rd[0], 1'b1);
    end
  endtask
  task automatic t_ram_rw();
    do_op(2'h1, 13'h0000, 8'h5A, rd);
    do_op(2'h1, 13'h1FFF, 8'hA5, rd);
    do_op(2'h0, 13'h0000, 8'h00, rd);
    check(rd, 8'h5A);
    do_op(2'h0, 13'h1FFF, 8'h00, rd);
    check(rd, 8'hA5);
  endtask
  task automatic t_token();
    do_op(2'h3, 13'h0003, 8'hFE, rd);
    do_op(2'h2, 13'h0003, 8'h00, rd);
    check(rd[0], 1'b0);
    // Far port takes token 4; the fresh select pulse of the next token read shows it
    u_dpac_ram_model.tokFree[4] = 1'b0;
    do_op(2'h2, 13'h0004, 8'h00, rd);
    check(rd[0], 1'b0);
    do_op(2'h3, 13'h0003, 8'h01, rd);
    do_op(2'h2, 13'h0003, 8'h00, rd);
    check(rd[0], 1'b1);
  endtask
  task automatic t_busy();
    busyHold <= 1'b1;
    done = 1'b0;
    fork
      begin
        do_op(2'h1, 13'h0ABC, 8'h3C, rd);
        done = 1'b1;
      end
      begin
        repeat (30) @(posedge mclk);
        check(done, 1'b0);
        busyHold <= 1'b0;
      end
    join
    do_op(2'h0, 13'h0ABC, 8'h00, rd);
    check(rd, 8'h3C);
  endtask
  // Low enable freezes the block: a request is not taken
  task automatic t_freeze();
    clkEn    <= 1'b0;
    reqOp    <= 2'h1;
    reqAddr  <= 13'h0000;
    reqData  <= 8'hC3;
    reqValid <= 1'b1;
    repeat (5) @(posedge mclk);
    check({reqReady, ramSelN, writeN, rspValid}, 4'hE);
    reqValid <= 1'b0;
    clkEn    <= 1'b1;
    @(posedge mclk);
    do_op(2'h0, 13'h0000, 8'h00, rd);
    check(rd, 8'h5A);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Strobe stays high for reads and address moves
  always @(posedge mclk)
  begin
    if (!reset && !outEnN)
      check(writeN, 1'b1);
    if (!reset && addr !== prevAddr)
      check(writeN, 1'b1);
    prevAddr <= addr;
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  initial
  begin
    {reset, clkEn, reqValid, busyHold} = 4'hC;
    {reqOp, reqAddr, reqData} = '0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_idle_tokens();
    t_ram_rw();
    t_token();
    t_busy();
    t_freeze();
    print_verdict();
  end
endmodule
